// ==== include/phbp_pkg.sv ====
// Constants and types of the bus agent
//
// Behaviour
// [RQ1] Interrupt line held low until software clears
// [RQ2] Request line asserted low to seek bus
// [RQ3] Arbiter grants exactly one agent, low active
// [RQ4] Lock leaves unlocked addresses open
// [RQ5] Bus reset initialises all agents; the agent's interrupt line keeps its level through it
// [RQ6] Port drives the bus clock to agents
// [RQ7] System error reported synchronously to bus clock
// [RQ8] Parity error driven two clocks after data
// [RQ9] Parity error only from master or target
// [RQ10] Address phase is first framed clock
// [RQ11] Byte 0 on bits 7:0, bursts allowed
// [RQ12] Word moves when both ready lines asserted
// [RQ13] Target ready: read data or write accept
// [RQ14] Initiator ready: write data or read accept
// [RQ15] Target asserts stop to end transaction
// [RQ16] Device select tells master a target claimed
// [RQ17] Command in address phase, byte enables after
// [RQ18] Frame held during burst, dropped for last
// [RQ19] Even parity valid one clock after phase
// [RQ20] Master drives parity for address and writes
// [RQ21] Arbiter grants one master, fair rotation
package phbp_pkg;

	// ----------------------------------------
	// Bus commands
	// ----------------------------------------
	localparam logic [3:0] CMD_MEM_READ = 4'h6;
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7;

	// ----------------------------------------
	// Timing counts, in bus clocks
	// ----------------------------------------
	// Clocks without device select before the master gives up
	localparam logic [2:0] ABORT_CLKS = 3'h5;

	// ----------------------------------------
	// Buffer shape
	// ----------------------------------------
	localparam int FIFO_WIDTH = 32;
	localparam int FIFO_DEPTH = 16;

	// ----------------------------------------
	// Synchronised pin vector layout
	// ----------------------------------------
	localparam int SYN_W = 41;
	localparam int SYN_BCLK = 40;
	localparam int SYN_BRSTN = 39;
	localparam int SYN_GNT = 38;
	localparam int SYN_FRAME = 37;
	localparam int SYN_IRDY = 36;
	localparam int SYN_TRDY = 35;
	localparam int SYN_DEVSEL = 34;
	localparam int SYN_STOP = 33;
	localparam int SYN_PAR = 32;
	// Clock low, bus reset asserted, all other lines idle high
	localparam logic [40:0] SYN_RST = 41'h07F_FFFF_FFFF;
	localparam logic [39:0] SAMP_RST = 40'h7F_FFFF_FFFF;

	// ----------------------------------------
	// Master sequencer states, Gray along the path
	// ----------------------------------------
	typedef enum logic [2:0] {
		PHBP_IDLE = 3'h0,
		PHBP_REQ = 3'h1,
		PHBP_ADDR = 3'h3,
		PHBP_DATA = 3'h2,
		PHBP_TURN = 3'h6
	} phbp_state_t;

endpackage

// ==== logic/phbp_sync.sv ====
// Two flip-flop synchroniser for a vector of independent pin levels
`timescale 1ns/10ps
module phbp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Levels in and out
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	// ----------------------------------------
	// One stage pair per bit
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic meta_r; // First stage
			logic hold_r; // Second stage, safe to use
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					meta_r <= RST_VAL[gi];
					hold_r <= RST_VAL[gi];
				end else if (ce_i) begin
					meta_r <= d_i[gi];
					hold_r <= meta_r;
				end
			end
			assign q_o[gi] = hold_r;
		end
	endgenerate

endmodule

// ==== logic/phbp_fifo.sv ====
// Write data buffer with valid/ready on both sides
`timescale 1ns/10ps
module phbp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // Storage
	logic [AW-1:0] wptr_r, wptr_nxt; // Write index
	logic [AW-1:0] rptr_r, rptr_nxt; // Read index
	logic [AW:0] cnt_r, cnt_nxt; // Words held
	logic full_r, full_nxt; // Registered full flag
	logic empty_r, empty_nxt; // Registered empty flag
	logic push, pop;

	// ----------------------------------------
	// Next pointers and flags
	// ----------------------------------------
	always_comb begin
		push = in_valid_i & ~full_r;
		pop = out_ready_i & ~empty_r;
		wptr_nxt = push ? wptr_r + 1'b1 : wptr_r;
		rptr_nxt = pop ? rptr_r + 1'b1 : rptr_r;
		cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		full_nxt = (cnt_nxt == (AW+1)'(DEPTH));
		empty_nxt = (cnt_nxt == '0);
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r <= '0;
			full_r <= 1'b0;
			empty_r <= 1'b1;
		end else if (ce_i) begin
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
			cnt_r <= cnt_nxt;
			full_r <= full_nxt;
			empty_r <= empty_nxt;
		end
	end

	// Storage has no reset; only written words are ever read
	always_ff @(posedge clk_i) begin
		if (ce_i && push) begin
			mem[wptr_r] <= in_data_i;
		end
	end

	assign in_ready_o = ~full_r;
	assign out_valid_o = ~empty_r;
	assign out_data_o = mem[rptr_r];

endmodule

// ==== logic/phbp_agent.sv ====
// Bus master agent that requests, frames and bursts data on the port's bus
`timescale 1ns/10ps
module phbp_agent (
	// System clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Clock and reset made by the port
	input wire logic downstream_bus_clock_i,
	input wire logic downstream_bus_reset_n_i,
	// Arbitration
	output logic agent_bus_request_0_n_o,
	input wire logic agent_bus_grant_0_n_i,
	// Framing and handshake
	input wire logic frame_n_i,
	output logic frame_n_o,
	output logic frame_oe_o,
	input wire logic irdy_n_i,
	output logic irdy_n_o,
	output logic irdy_oe_o,
	input wire logic trdy_n_i,
	input wire logic devsel_n_i,
	input wire logic stop_n_i,
	// Address, data, command, parity
	input wire logic [31:0] addr_data_bus_i,
	output logic [31:0] addr_data_bus_o,
	output logic addr_data_bus_oe_o,
	output logic [3:0] cbe_n_o,
	output logic cbe_oe_o,
	input wire logic bus_parity_i,
	output logic bus_parity_o,
	output logic bus_parity_oe_o,
	// Error and interrupt lines
	output logic perr_n_o,
	output logic perr_oe_o,
	output logic serr_n_o,
	output logic serr_oe_o,
	output logic int_n_o,
	output logic int_oe_o,
	// User command
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic cmd_write_i,
	input wire logic [31:0] cmd_addr_i,
	input wire logic [3:0] cmd_count_i,
	input wire logic [3:0] cmd_be_n_i,
	// User write data
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	input wire logic [31:0] wr_data_i,
	// User read data and status
	output logic rd_valid_o,
	output logic [31:0] rd_data_o,
	output logic done_o,
	output logic abort_o,
	output logic perr_seen_o,
	// Software events
	input wire logic int_set_i,
	input wire logic int_clear_i,
	input wire logic serr_req_i
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [40:0] syn_q; // Synchronised pins
	logic [39:0] samp_r, samp_nxt; // Pins captured mid bus clock
	logic bclk_prev_r, bclk_prev_nxt; // Last synced bus clock
	logic brise, bfall; // Bus clock edges
	logic bus_up; // Port has released bus reset
	phbp_pkg::phbp_state_t state_r, state_nxt;
	logic req_n_r, req_n_nxt;
	logic frame_n_r, frame_n_nxt, frame_oe_r, frame_oe_nxt;
	logic irdy_n_r, irdy_n_nxt, irdy_oe_r, irdy_oe_nxt;
	logic [31:0] ad_r, ad_nxt;
	logic ad_oe_r, ad_oe_nxt;
	logic [3:0] cbe_r, cbe_nxt;
	logic cbe_oe_r, cbe_oe_nxt;
	logic par_r, par_nxt, par_oe_r, par_oe_nxt;
	logic perr_n_r, perr_n_nxt, perr_oe_r, perr_oe_nxt;
	logic pend_r, pend_nxt; // Read word awaiting its parity
	logic chk_r, chk_nxt; // Parity computed from that word
	logic perr_hit_r, perr_hit_nxt; // Mismatch to drive next clock
	logic serr_pend_r, serr_pend_nxt;
	logic serr_n_r, serr_n_nxt, serr_oe_r, serr_oe_nxt;
	logic int_n_r, int_n_nxt, int_oe_r, int_oe_nxt;
	logic write_r, write_nxt;
	logic [31:0] addr_r, addr_nxt;
	logic [3:0] be_r, be_nxt;
	logic [4:0] left_r, left_nxt; // Words still to move
	logic [2:0] dsel_r, dsel_nxt; // Clocks without device select
	logic cmd_ready_r, cmd_ready_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [31:0] rd_data_r, rd_data_nxt;
	logic done_r, done_nxt, abort_r, abort_nxt, pseen_r, pseen_nxt;
	logic fifo_valid, fifo_pop;
	logic [31:0] fifo_data;
	logic xfer; // Data phase completes

	// ----------------------------------------
	// Pin synchroniser and write buffer
	// ----------------------------------------
	phbp_sync #(
		.WIDTH(phbp_pkg::SYN_W),
		.RST_VAL(phbp_pkg::SYN_RST)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i({downstream_bus_clock_i, downstream_bus_reset_n_i, agent_bus_grant_0_n_i, frame_n_i, irdy_n_i,
			trdy_n_i, devsel_n_i, stop_n_i, bus_parity_i, addr_data_bus_i}),
		.q_o(syn_q)
	);

	phbp_fifo #(
		.WIDTH(phbp_pkg::FIFO_WIDTH),
		.DEPTH(phbp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.in_valid_i(wr_valid_i),
		.in_ready_o(wr_ready_o),
		.in_data_i(wr_data_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_data)
	);

	// Port clock edges on our clock
	assign brise = syn_q[phbp_pkg::SYN_BCLK] & ~bclk_prev_r; // RQ6
	assign bfall = ~syn_q[phbp_pkg::SYN_BCLK] & bclk_prev_r;
	assign bus_up = syn_q[phbp_pkg::SYN_BRSTN];
	// Both ready lines low; ours as driven
	assign xfer = ~irdy_n_r & ~samp_r[phbp_pkg::SYN_TRDY]; // RQ12

	// ----------------------------------------
	// Next state of the whole agent
	// ----------------------------------------
	always_comb begin
		samp_nxt = samp_r;
		bclk_prev_nxt = syn_q[phbp_pkg::SYN_BCLK];
		state_nxt = state_r;
		req_n_nxt = req_n_r;
		frame_n_nxt = frame_n_r;
		frame_oe_nxt = frame_oe_r;
		irdy_n_nxt = irdy_n_r;
		irdy_oe_nxt = irdy_oe_r;
		ad_nxt = ad_r;
		ad_oe_nxt = ad_oe_r;
		cbe_nxt = cbe_r;
		cbe_oe_nxt = cbe_oe_r;
		par_nxt = par_r;
		par_oe_nxt = par_oe_r;
		perr_n_nxt = perr_n_r;
		perr_oe_nxt = perr_oe_r;
		pend_nxt = pend_r;
		chk_nxt = chk_r;
		perr_hit_nxt = perr_hit_r;
		serr_pend_nxt = serr_pend_r | serr_req_i;
		serr_n_nxt = serr_n_r;
		serr_oe_nxt = serr_oe_r;
		write_nxt = write_r;
		addr_nxt = addr_r;
		be_nxt = be_r;
		left_nxt = left_r;
		dsel_nxt = dsel_r;
		rd_data_nxt = rd_data_r;
		rd_valid_nxt = 1'b0;
		done_nxt = 1'b0;
		abort_nxt = 1'b0;
		pseen_nxt = pseen_r;
		fifo_pop = 1'b0;
		// Capture pins mid clock, once settled
		if (bfall) begin
			samp_nxt = syn_q[39:0];
		end
		// Interrupt stays until software clears; a new set wins
		int_oe_nxt = int_set_i | (int_oe_r & ~int_clear_i); // RQ1
		int_n_nxt = ~int_oe_nxt; // RQ1
		if (!bus_up) begin
			// Port holds the bus in reset: release every line except the interrupt, which keeps its level
			state_nxt = phbp_pkg::PHBP_IDLE; // RQ5
			req_n_nxt = 1'b1;
			frame_n_nxt = 1'b1;
			frame_oe_nxt = 1'b0;
			irdy_n_nxt = 1'b1;
			irdy_oe_nxt = 1'b0;
			ad_oe_nxt = 1'b0;
			cbe_oe_nxt = 1'b0;
			par_oe_nxt = 1'b0;
			perr_n_nxt = 1'b1;
			perr_oe_nxt = 1'b0;
			pend_nxt = 1'b0;
			perr_hit_nxt = 1'b0;
			serr_pend_nxt = 1'b0;
			serr_n_nxt = 1'b1;
			serr_oe_nxt = 1'b0;
		end else begin
			case (state_r)
				phbp_pkg::PHBP_IDLE: begin
					// Take a command between transactions only
					if (cmd_valid_i && cmd_ready_r) begin
						write_nxt = cmd_write_i;
						addr_nxt = cmd_addr_i;
						be_nxt = cmd_be_n_i;
						left_nxt = {1'b0, cmd_count_i} + 5'h01;
						state_nxt = phbp_pkg::PHBP_REQ;
					end
				end
				phbp_pkg::PHBP_REQ: begin
					if (brise) begin
						if (req_n_r) begin
							req_n_nxt = 1'b0; // RQ2
						end else if (!samp_r[phbp_pkg::SYN_GNT] && samp_r[phbp_pkg::SYN_FRAME] &&
							samp_r[phbp_pkg::SYN_IRDY]) begin
							// Granted, bus idle: address phase; lock is never consulted
							req_n_nxt = 1'b1; // RQ3 RQ21
							frame_n_nxt = 1'b0; // RQ10 RQ4
							frame_oe_nxt = 1'b1;
							irdy_n_nxt = 1'b1;
							irdy_oe_nxt = 1'b1;
							ad_nxt = addr_r; // RQ10
							ad_oe_nxt = 1'b1;
							cbe_nxt = write_r ? phbp_pkg::CMD_MEM_WRITE : phbp_pkg::CMD_MEM_READ; // RQ17
							cbe_oe_nxt = 1'b1;
							dsel_nxt = 3'h0;
							state_nxt = phbp_pkg::PHBP_ADDR;
						end
					end
				end
				phbp_pkg::PHBP_ADDR: begin
					if (brise) begin
						cbe_nxt = be_r; // RQ17
						state_nxt = phbp_pkg::PHBP_DATA;
						if (write_r) begin
							// First word once buffered
							if (fifo_valid) begin
								fifo_pop = 1'b1;
								ad_nxt = fifo_data; // RQ11
								irdy_n_nxt = 1'b0; // RQ14
								frame_n_nxt = (left_r == 5'h01); // RQ18
							end
						end else begin
							// Target drives read data
							ad_oe_nxt = 1'b0;
							irdy_n_nxt = 1'b0; // RQ14
							frame_n_nxt = (left_r == 5'h01); // RQ18
						end
					end
				end
				phbp_pkg::PHBP_DATA: begin
					if (brise) begin
						dsel_nxt = samp_r[phbp_pkg::SYN_DEVSEL] ? dsel_r + 3'h1 : dsel_r; // RQ16
						if (xfer) begin
							left_nxt = left_r - 5'h01;
							if (!write_r) begin
								// Target has valid read data
								rd_data_nxt = samp_r[31:0]; // RQ13
								rd_valid_nxt = 1'b1;
								chk_nxt = ^{samp_r[31:0], cbe_r};
							end
						end
						if (xfer && frame_n_r) begin
							// Last data phase completed
							frame_oe_nxt = 1'b1;
							irdy_n_nxt = 1'b1;
							ad_oe_nxt = 1'b0;
							done_nxt = 1'b1;
							state_nxt = phbp_pkg::PHBP_TURN;
						end else if (samp_r[phbp_pkg::SYN_DEVSEL] && dsel_r == phbp_pkg::ABORT_CLKS) begin
							// Nobody claimed the access
							frame_n_nxt = 1'b1;
							irdy_n_nxt = 1'b1;
							ad_oe_nxt = 1'b0;
							abort_nxt = 1'b1;
							state_nxt = phbp_pkg::PHBP_TURN;
						end else if (!samp_r[phbp_pkg::SYN_STOP] && frame_n_r && !irdy_n_r) begin
							// Stop on the last phase ends it
							irdy_n_nxt = 1'b1; // RQ15
							ad_oe_nxt = 1'b0;
							abort_nxt = 1'b1;
							state_nxt = phbp_pkg::PHBP_TURN;
						end else if (write_r && (xfer || irdy_n_r)) begin
							// Next write word, or wait with ready high
							if (fifo_valid) begin
								fifo_pop = 1'b1;
								ad_nxt = fifo_data;
								irdy_n_nxt = 1'b0; // RQ14
								frame_n_nxt = frame_n_r | (left_nxt == 5'h01); // RQ18
							end else begin
								irdy_n_nxt = 1'b1;
							end
						end else if (xfer) begin
							frame_n_nxt = frame_n_r | (left_nxt == 5'h01); // RQ18
						end
						// Frame may only drop while ready is low
						if (!samp_r[phbp_pkg::SYN_STOP] && !frame_n_r && !irdy_n_r) begin
							frame_n_nxt = 1'b1; // RQ15
						end
					end
				end
				phbp_pkg::PHBP_TURN: begin
					if (brise) begin
						// Driven high one clock; now release
						frame_n_nxt = 1'b1;
						frame_oe_nxt = 1'b0;
						irdy_n_nxt = 1'b1;
						irdy_oe_nxt = 1'b0;
						cbe_oe_nxt = 1'b0;
						state_nxt = phbp_pkg::PHBP_IDLE;
					end
				end
				default: begin
					state_nxt = phbp_pkg::PHBP_IDLE;
				end
			endcase
			if (brise) begin
				// Parity follows the driven word by one clock
				par_nxt = ^{ad_r, cbe_r}; // RQ19
				par_oe_nxt = ad_oe_r; // RQ20
				// Read parity one clock after data, error two after
				perr_hit_nxt = pend_r & (chk_r ^ samp_r[phbp_pkg::SYN_PAR]); // RQ8
				pend_nxt = (state_r == phbp_pkg::PHBP_DATA) & xfer & ~write_r; // RQ9
				perr_n_nxt = ~perr_hit_r; // RQ8
				perr_oe_nxt = perr_hit_r | ~perr_n_r;
				pseen_nxt = pseen_r | perr_hit_r;
				// System error low for one bus clock
				serr_n_nxt = ~serr_pend_r; // RQ7
				serr_oe_nxt = serr_pend_r;
				serr_pend_nxt = serr_req_i;
			end
		end
		cmd_ready_nxt = bus_up && (state_nxt == phbp_pkg::PHBP_IDLE);
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			samp_r <= phbp_pkg::SAMP_RST;
			bclk_prev_r <= 1'b0;
			state_r <= phbp_pkg::PHBP_IDLE;
			req_n_r <= 1'b1;
			frame_n_r <= 1'b1;
			frame_oe_r <= 1'b0;
			irdy_n_r <= 1'b1;
			irdy_oe_r <= 1'b0;
			ad_r <= 32'h0000_0000;
			ad_oe_r <= 1'b0;
			cbe_r <= 4'hF;
			cbe_oe_r <= 1'b0;
			par_r <= 1'b0;
			par_oe_r <= 1'b0;
			perr_n_r <= 1'b1;
			perr_oe_r <= 1'b0;
			pend_r <= 1'b0;
			chk_r <= 1'b0;
			perr_hit_r <= 1'b0;
			serr_pend_r <= 1'b0;
			serr_n_r <= 1'b1;
			serr_oe_r <= 1'b0;
			int_n_r <= 1'b1;
			int_oe_r <= 1'b0;
			write_r <= 1'b0;
			addr_r <= 32'h0000_0000;
			be_r <= 4'h0;
			left_r <= 5'h00;
			dsel_r <= 3'h0;
			cmd_ready_r <= 1'b0;
			rd_valid_r <= 1'b0;
			rd_data_r <= 32'h0000_0000;
			done_r <= 1'b0;
			abort_r <= 1'b0;
			pseen_r <= 1'b0;
		end else if (ce_i) begin
			samp_r <= samp_nxt;
			bclk_prev_r <= bclk_prev_nxt;
			state_r <= state_nxt;
			req_n_r <= req_n_nxt;
			frame_n_r <= frame_n_nxt;
			frame_oe_r <= frame_oe_nxt;
			irdy_n_r <= irdy_n_nxt;
			irdy_oe_r <= irdy_oe_nxt;
			ad_r <= ad_nxt;
			ad_oe_r <= ad_oe_nxt;
			cbe_r <= cbe_nxt;
			cbe_oe_r <= cbe_oe_nxt;
			par_r <= par_nxt;
			par_oe_r <= par_oe_nxt;
			perr_n_r <= perr_n_nxt;
			perr_oe_r <= perr_oe_nxt;
			pend_r <= pend_nxt;
			chk_r <= chk_nxt;
			perr_hit_r <= perr_hit_nxt;
			serr_pend_r <= serr_pend_nxt;
			serr_n_r <= serr_n_nxt;
			serr_oe_r <= serr_oe_nxt;
			int_n_r <= int_n_nxt;
			int_oe_r <= int_oe_nxt;
			write_r <= write_nxt;
			addr_r <= addr_nxt;
			be_r <= be_nxt;
			left_r <= left_nxt;
			dsel_r <= dsel_nxt;
			cmd_ready_r <= cmd_ready_nxt;
			rd_valid_r <= rd_valid_nxt;
			rd_data_r <= rd_data_nxt;
			done_r <= done_nxt;
			abort_r <= abort_nxt;
			pseen_r <= pseen_nxt;
		end
	end

	// ----------------------------------------
	// Outputs, each straight from a flip-flop
	// ----------------------------------------
	assign agent_bus_request_0_n_o = req_n_r;
	assign frame_n_o = frame_n_r;
	assign frame_oe_o = frame_oe_r;
	assign irdy_n_o = irdy_n_r;
	assign irdy_oe_o = irdy_oe_r;
	assign addr_data_bus_o = ad_r;
	assign addr_data_bus_oe_o = ad_oe_r;
	assign cbe_n_o = cbe_r;
	assign cbe_oe_o = cbe_oe_r;
	assign bus_parity_o = par_r;
	assign bus_parity_oe_o = par_oe_r;
	assign perr_n_o = perr_n_r;
	assign perr_oe_o = perr_oe_r;
	assign serr_n_o = serr_n_r;
	assign serr_oe_o = serr_oe_r;
	assign int_n_o = int_n_r;
	assign int_oe_o = int_oe_r;
	assign cmd_ready_o = cmd_ready_r;
	assign rd_valid_o = rd_valid_r;
	assign rd_data_o = rd_data_r;
	assign done_o = done_r;
	assign abort_o = abort_r;
	assign perr_seen_o = pseen_r;

endmodule

// ==== verif/phbp_monitor.sv ====
// Concurrent checks on the bus agent's ports
`timescale 1ns/10ps
module phbp_monitor (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Arbitration and framing
	input wire logic agent_bus_grant_0_n_i,
	input wire logic agent_bus_request_0_n_o,
	input wire logic frame_n_o,
	input wire logic frame_oe_o,
	input wire logic irdy_n_o,
	input wire logic irdy_oe_o,
	// Address, data, parity
	input wire logic [31:0] addr_data_bus_o,
	input wire logic addr_data_bus_oe_o,
	input wire logic [3:0] cbe_n_o,
	input wire logic bus_parity_o,
	// Error and interrupt lines
	input wire logic perr_n_o,
	input wire logic perr_oe_o,
	input wire logic perr_seen_o,
	input wire logic serr_n_o,
	input wire logic serr_oe_o,
	input wire logic int_n_o,
	input wire logic int_oe_o,
	input wire logic int_set_i,
	input wire logic int_clear_i,
	// User status
	input wire logic rd_valid_o,
	input wire logic done_o,
	input wire logic abort_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// --------
	// Properties
	// --------
	frame_gnt_a: assert property ($fell(frame_n_o) && frame_oe_o |-> !agent_bus_grant_0_n_i)
		else $error("frame without grant");
	req_drop_a: assert property ($fell(frame_n_o) && frame_oe_o |-> agent_bus_request_0_n_o)
		else $error("request held in address phase");
	done_frame_a: assert property (done_o |-> frame_n_o)
		else $error("done while frame low");
	rd_xfer_a: assert property (rd_valid_o |-> $past(irdy_oe_o, 2) && !$past(irdy_n_o, 2))
		else $error("read word without ready");
	serr_drain_a: assert property (serr_oe_o |-> !serr_n_o)
		else $error("system error driven high");
	perr_flag_a: assert property (perr_oe_o && !perr_n_o |=> perr_seen_o)
		else $error("parity error not flagged");
	int_set_a: assert property (int_set_i |=> int_oe_o && !int_n_o)
		else $error("interrupt not raised");
	int_hold_a: assert property (int_oe_o && !int_clear_i |=> int_oe_o)
		else $error("interrupt dropped early");
	par_even_a: assert property ($past(addr_data_bus_oe_o) && $changed({addr_data_bus_o, cbe_n_o})
		|=> bus_parity_o == ^$past({addr_data_bus_o, cbe_n_o}, 2))
		else $error("parity not even");
	// Main scenarios reached
	done_c: cover property (done_o);
	abort_c: cover property (abort_o);
	perr_c: cover property (perr_oe_o && !perr_n_o);
endmodule
bind phbp_agent phbp_monitor i_mon (.*);

// ==== verif/phbp_port_model.sv ====
// Port model: bus clock, bus reset, arbiter and memory target
`timescale 1ns/10ps
module phbp_port_model (
	// System side
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [1:0] mode_i,
	// Agent lines
	input wire logic req_n_i,
	input wire logic frame_n_i,
	input wire logic irdy_n_i,
	input wire logic [31:0] ad_i,
	input wire logic [3:0] cbe_i,
	// Port lines
	output logic bclk_o,
	output logic brst_n_o,
	output logic gnt_n_o,
	output logic trdy_n_o,
	output logic devsel_n_o,
	output logic [31:0] ad_o,
	output logic ad_oe_o,
	output logic par_o,
	output logic par_oe_o
);
	logic [3:0] div; // Half bus period in clk
	logic act; // Access claimed or pending
	logic rd; // Access is a read
	logic [31:0] nxt; // Next word address
	logic [31:0] wq[$]; // Words written
	wire xfer = !irdy_n_i && !trdy_n_o; // Both ready lines low
	// --------
	// Every port line except the clock moves on the bus clock rise
	// --------
	always @(posedge clk_i) begin
		div <= rst_i ? 4'h0 : div + 4'h1;
		if (rst_i) begin
			bclk_o <= 1'b0; // Clock stands still in reset
			brst_n_o <= 1'b0;
			gnt_n_o <= 1'b1;
			trdy_n_o <= 1'b1;
			devsel_n_o <= 1'b1;
			ad_oe_o <= 1'b0;
			par_oe_o <= 1'b0;
			act <= 1'b0;
		end else if (div == 4'hF) begin
			bclk_o <= !bclk_o;
			if (!bclk_o) begin
				brst_n_o <= 1'b1;
				// Grant held until the bus is idle
				if (!req_n_i) begin
					gnt_n_o <= 1'b0;
				end else if (frame_n_i && irdy_n_i) begin
					gnt_n_o <= 1'b1;
				end
				// Parity trails our word by one clock; mode 3 spoils it
				par_o <= ^{ad_o, cbe_i} ^ (mode_i == 2'h3);
				par_oe_o <= ad_oe_o;
				if (!act && !frame_n_i) begin
					act <= 1'b1;
					rd <= cbe_i == phbp_pkg::CMD_MEM_READ;
					nxt <= ad_i;
					devsel_n_o <= mode_i == 2'h2;
				end else if (act && frame_n_i && irdy_n_i) begin
					// Bus idle again, also after a master abort
					act <= 1'b0;
					devsel_n_o <= 1'b1;
					trdy_n_o <= 1'b1;
					ad_oe_o <= 1'b0;
				end else if (act && !devsel_n_o) begin
					if (xfer && !rd) begin
						wq.push_back(ad_i);
					end
					nxt <= xfer ? nxt + 32'h4 : nxt;
					ad_o <= xfer ? nxt + 32'h4 : nxt;
					// Mode 1 waits after each word
					trdy_n_o <= xfer && (frame_n_i || mode_i == 2'h1);
					ad_oe_o <= rd && !(xfer && frame_n_i);
				end
			end
		end
	end
endmodule

// ==== verif/phbp_testbench.sv ====
// Self-checking bench for the bus agent
`timescale 1ns/10ps
module testbench;
	// --------
	// Signals
	// --------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1; // Never frozen
	logic stop_n_i = 1'b1; // Model never stops
	logic [3:0] cmd_be_n_i = 4'h0; // All lanes on
	logic cmd_valid_i = 1'b0, cmd_write_i = 1'b0, wr_valid_i = 1'b0;
	logic int_set_i = 1'b0, int_clear_i = 1'b0, serr_req_i = 1'b0;
	logic [31:0] cmd_addr_i = 32'h0, wr_data_i = 32'h0;
	logic [3:0] cmd_count_i = 4'h0;
	logic [1:0] mode = 2'h0; // Target behaviour
	logic downstream_bus_clock_i, downstream_bus_reset_n_i, agent_bus_grant_0_n_i, trdy_n_i, devsel_n_i;
	logic frame_n_i, irdy_n_i, bus_parity_i, m_ad_oe, m_par, m_par_oe;
	logic [31:0] addr_data_bus_i, addr_data_bus_o, rd_data_o, m_ad;
	logic [3:0] cbe_n_o;
	logic agent_bus_request_0_n_o, frame_n_o, frame_oe_o, irdy_n_o, irdy_oe_o, addr_data_bus_oe_o, cbe_oe_o;
	logic bus_parity_o, bus_parity_oe_o, perr_n_o, perr_oe_o, serr_n_o, serr_oe_o, int_n_o, int_oe_o;
	logic cmd_ready_o, wr_ready_o, rd_valid_o, done_o, abort_o, perr_seen_o;
	logic got_done, got_abort;
	logic [31:0] rq[$]; // Read words seen
	int bad_count = 0;
	int n_checks = 0;
	// Pull-ups; a released data bus shows a moving pattern
	assign frame_n_i = frame_oe_o ? frame_n_o : 1'b1;
	assign irdy_n_i = irdy_oe_o ? irdy_n_o : 1'b1;
	assign addr_data_bus_i = addr_data_bus_oe_o ? addr_data_bus_o :
		m_ad_oe ? m_ad : {32{downstream_bus_clock_i}} ^ 32'hC3A5_5A3C;
	assign bus_parity_i = bus_parity_oe_o ? bus_parity_o : m_par_oe ? m_par : downstream_bus_clock_i;
	always #2.5 clk_i = !clk_i;
	phbp_agent i_dut (.*);
	phbp_port_model i_port (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .req_n_i(agent_bus_request_0_n_o),
		.frame_n_i(frame_n_i), .irdy_n_i(irdy_n_i), .ad_i(addr_data_bus_i),
		.cbe_i(cbe_oe_o ? cbe_n_o : 4'hF), .bclk_o(downstream_bus_clock_i),
		.brst_n_o(downstream_bus_reset_n_i), .gnt_n_o(agent_bus_grant_0_n_i), .trdy_n_o(trdy_n_i),
		.devsel_n_o(devsel_n_i), .ad_o(m_ad), .ad_oe_o(m_ad_oe), .par_o(m_par), .par_oe_o(m_par_oe));
	// --------
	// Shared tasks
	// --------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One command; gather read words until it ends
	task automatic run_cmd(input logic wr, input logic [31:0] a, input logic [3:0] n);
		int t;
		cmd_write_i <= wr;
		cmd_addr_i <= a;
		cmd_count_i <= n;
		cmd_valid_i <= 1'b1;
		do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
		cmd_valid_i <= 1'b0;
		rq.delete();
		got_done = 1'b0;
		got_abort = 1'b0;
		t = 0;
		while (!got_done && !got_abort && t < 4000) begin
			@(posedge clk_i);
			t++;
			if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
			got_done = done_o === 1'b1;
			got_abort = abort_o === 1'b1;
		end
	endtask
	// --------
	// Scenarios
	// --------
	// Fill buffer past full, drain in one slow burst
	task automatic t_fifo();
		int i;
		mode <= 2'h1;
		for (i = 0; i < 16; i++) begin
			wr_valid_i <= 1'b1;
			wr_data_i <= 32'hA500_0000 + 32'(i);
			do @(posedge clk_i); while (wr_ready_o !== 1'b1);
		end
		wr_data_i <= 32'hDEAD_0000;
		repeat (3) @(posedge clk_i);
		chk(wr_ready_o, 1'b0);
		wr_valid_i <= 1'b0;
		run_cmd(1'b1, 32'h0000_1000, 4'hF);
		chk(got_done, 1'b1);
		chk(i_port.wq.size(), 16);
		for (i = 0; i < 16; i++) chk(i_port.wq[i], 32'hA500_0000 + 32'(i));
		chk(wr_ready_o, 1'b1);
	endtask
	// Read burst; parity error flag only on a spoiled read
	task automatic t_read(input logic [1:0] m, input logic [31:0] a, input logic [3:0] n);
		int i;
		mode <= m;
		run_cmd(1'b0, a, n);
		repeat (100) @(posedge clk_i);
		chk(got_done, 1'b1);
		chk(rq.size(), n + 1);
		for (i = 0; i < rq.size(); i++) chk(rq[i], a + 32'(4 * i));
		chk(perr_seen_o, m == 2'h3);
	endtask
	// No target claims the access
	task automatic t_abort();
		mode <= 2'h2;
		run_cmd(1'b0, 32'h0000_5000, 4'h2);
		chk(got_abort, 1'b1);
		chk(rq.size(), 0);
	endtask
	// Interrupt until cleared, then one system error
	task automatic t_events();
		int t;
		int_set_i <= 1'b1;
		@(posedge clk_i);
		int_set_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		chk({int_oe_o, int_n_o}, 2'h2);
		int_clear_i <= 1'b1;
		@(posedge clk_i);
		int_clear_i <= 1'b0;
		@(posedge clk_i);
		chk(int_oe_o, 1'b0);
		serr_req_i <= 1'b1;
		@(posedge clk_i);
		serr_req_i <= 1'b0;
		t = 0;
		while (serr_oe_o !== 1'b1 && t < 100) begin
			@(posedge clk_i);
			t++;
		end
		chk({serr_oe_o, serr_n_o}, 2'h2);
	endtask
	task automatic close_out();
		$display("Checks made %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// --------
	// Main sequence and watchdog
	// --------
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_fifo();
		t_read(2'h0, 32'h0000_2000, 4'h3);
		t_read(2'h1, 32'h0000_3FF0, 4'h0);
		t_abort();
		t_read(2'h3, 32'h0000_4000, 4'h1);
		t_events();
		close_out();
	end
	initial begin
		repeat (60000) @(posedge clk_i);
		bad_count++;
		close_out();
	end
endmodule
